/* File: core/prs_pkg.sv */
package prs_pkg;

    // ------------------------------------------------------------------
    // register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_LOOP_MAIN   = 10'h010;
    localparam logic [ADDR_W-1:0] OFF_PUMP_STEP   = 10'h014;
    localparam logic [ADDR_W-1:0] OFF_DET_PULSE   = 10'h017;
    localparam logic [ADDR_W-1:0] OFF_MON_CONFIG  = 10'h01b;
    localparam logic [ADDR_W-1:0] OFF_REF_INPUT   = 10'h01c;
    localparam logic [ADDR_W-1:0] OFF_REF_STATUS  = 10'h01f;
    localparam logic [ADDR_W-1:0] OFF_UPDATE      = 10'h232;
    localparam logic [DATA_W-1:0] UPDATE_VALUE    = 8'h01;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_LOOP_MAIN   = 8'h01;
    localparam logic [DATA_W-1:0] RST_ZERO        = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int LOOP_POL       = 7;
    localparam int LOOP_MODE_HI   = 6;
    localparam int LOOP_MODE_LO   = 4;
    localparam int LOOP_PWR_HI    = 1;
    localparam int LOOP_PWR_LO    = 0;
    localparam int PULSE_HI       = 1;
    localparam int PULSE_LO       = 0;
    localparam int STEP_HI        = 2;
    localparam int STEP_LO        = 0;
    localparam int MON_PIN_HI     = 2;
    localparam int MON_PIN_LO     = 0;
    localparam int MON_STAT_HI    = 6;
    localparam int MON_STAT_LO    = 4;
    localparam int RI_DEGLITCH_OFF = 7;
    localparam int RI_USE_PIN     = 6;
    localparam int RI_AUTO        = 5;
    localparam int RI_MAN_SECOND  = 4;
    localparam int RI_PREF_SECOND = 3;
    localparam int RI_SECOND_EN   = 2;
    localparam int RI_FIRST_EN    = 1;
    localparam int RI_DIFF        = 0;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] PWR_NORMAL     = 2'h0;
    localparam logic [2:0] PM_HIZ         = 3'h0;
    localparam logic [2:0] PM_UP          = 3'h1;
    localparam logic [2:0] PM_DOWN        = 3'h2;
    localparam logic [2:0] PM_NORMAL      = 3'h3;
    localparam logic [2:0] MON_FIRST_BAD  = 3'h7;
    localparam logic [2:0] MON_SECOND_BAD = 3'h6;
    localparam logic [2:0] MON_ON_SECOND  = 3'h5;
    localparam logic [2:0] PULSE_BASE     = 3'h1;
    localparam logic [3:0] STEP_BASE      = 4'h1;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 8;
    localparam int LOSS_TIME_NS  = 1000;
    localparam int LOSS_CYCLES   = LOSS_TIME_NS / CLK_PERIOD_NS;
    localparam int ALIGN_TIME_NS = 40;
    localparam int ALIGN_CYCLES  = ALIGN_TIME_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        PRS_DG_IDLE     = 2'b00,
        PRS_DG_WAIT_FB  = 2'b01,
        PRS_DG_WAIT_REF = 2'b11
    } prs_deglitch_e;

endpackage

/* File: core/prs_ctrl.sv */
// How it works
// - polarity bit set swaps pump sense
// - staged settings apply only on update write
// - two-bit field sets dead-zone pulse width
// - pump mode: hold, track, force up, down
// - eight current steps scale nominal pump current
// - normal mode: leading input picks up/down
// - input control picks differential or single-ended
// - all reference inputs off after reset
// - differential receiver off unless selected and powered
// - single-ended buffers off by loop or own bit
// - differential mode powers down single-ended buffers
// - switchover only outside differential mode
// - manual select from register or pin
// - monitor high while first reference invalid
// - monitor low and revert when first returns
// - status pin option, second may be preferred
// - deglitch blocks misaligned edges after a switch
// - automatic switching always reverts to preferred
// - loop power field zero runs, else down
`timescale 1ns/10ps
`default_nettype none

module prs_ctrl
    import prs_pkg::*;
#(
    parameter int LOSS_LIMIT  = LOSS_CYCLES,
    parameter int ALIGN_LIMIT = ALIGN_CYCLES
)
(
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_write,
    input  wire logic              i_read,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic              i_first_reference,
    input  wire logic              i_second_reference,
    input  wire logic              i_ref_divided,
    input  wire logic              i_feedback_divided,
    input  wire logic              i_reference_input_pin_select,
    output logic                   o_pump_up,
    output logic                   o_pump_down,
    output logic                   o_pump_hiz,
    output logic      [3:0]        o_pump_current_units,
    output logic                   o_loop_powered,
    output logic                   o_diff_receiver_on,
    output logic                   o_first_buffer_on,
    output logic                   o_second_buffer_on,
    output logic                   o_active_second,
    output logic                   o_ref_loss_monitor_out,
    output logic                   o_status_out
);
    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] sh_loop, sh_step, sh_pulse, sh_mon, sh_reference_input_pin;
    logic [DATA_W-1:0] act_loop, act_step, act_pulse, act_mon, act_reference_input_pin;
    logic [4:0]        raw_in, sync1, sync2, sync3, stable, stable_d, rise;
    logic              loop_on, diff_sel, rx_on [2];
    logic [7:0]        idle_cnt [2];
    logic              ref_valid [2];
    logic              next_second, sel_second;
    prs_deglitch_e     dg_state;
    logic [7:0]        align_cnt;
    logic              ref_pass, det_up, det_down, drive_up, drive_down;
    logic              update_hit;
    logic [2:0]        clr_cnt, pulse_len, pump_mode;
    logic [7:0]        pick; // indication source per monitor code
    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    // writes land in the shadow copies
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            sh_loop  <= RST_LOOP_MAIN;
            sh_step  <= RST_ZERO;
            sh_pulse <= RST_ZERO;
            sh_mon   <= RST_ZERO;
            sh_reference_input_pin <= RST_ZERO;
        end
        else if (i_write)
        begin
            case (i_addr)
                OFF_LOOP_MAIN:  sh_loop  <= i_wdata;
                OFF_PUMP_STEP:  sh_step  <= i_wdata;
                OFF_DET_PULSE:  sh_pulse <= i_wdata;
                OFF_MON_CONFIG: sh_mon   <= i_wdata;
                OFF_REF_INPUT:  sh_reference_input_pin <= i_wdata;
                default:        ;
            endcase
        end
    end
    assign update_hit = i_write && (i_addr == OFF_UPDATE)
                        && (i_wdata == UPDATE_VALUE);
    // update write commits every shadow at once
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            act_loop  <= RST_LOOP_MAIN;
            act_step  <= RST_ZERO;
            act_pulse <= RST_ZERO;
            act_mon   <= RST_ZERO;
            act_reference_input_pin <= RST_ZERO;
        end
        else if (update_hit)
        begin
            act_loop  <= sh_loop;
            act_step  <= sh_step;
            act_pulse <= sh_pulse;
            act_mon   <= sh_mon;
            act_reference_input_pin <= sh_reference_input_pin;
        end
    end
    // read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge i_clock)
    begin
        if (i_rst || !i_read)
        begin
            o_rdata <= RST_ZERO;
        end
        else
        begin
            case (i_addr)
                OFF_LOOP_MAIN:  o_rdata <= sh_loop;
                OFF_PUMP_STEP:  o_rdata <= sh_step;
                OFF_DET_PULSE:  o_rdata <= sh_pulse;
                OFF_MON_CONFIG: o_rdata <= sh_mon;
                OFF_REF_INPUT:  o_rdata <= sh_reference_input_pin;
                OFF_REF_STATUS: o_rdata <= {2'h0, o_pump_hiz, o_status_out,
                                            o_ref_loss_monitor_out,
                                            sel_second, ref_valid[1],
                                            ref_valid[0]};
                default:        o_rdata <= RST_ZERO;
            endcase
        end
    end
    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    assign raw_in = {i_reference_input_pin_select, i_feedback_divided,
                     i_ref_divided, i_second_reference, i_first_reference};
    // three stages, a change counts once stages two and three agree
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            sync1    <= 5'h00;
            sync2    <= 5'h00;
            sync3    <= 5'h00;
            stable   <= 5'h00;
            stable_d <= 5'h00;
        end
        else
        begin
            sync1    <= raw_in;
            sync2    <= sync1;
            sync3    <= sync2;
            stable   <= (sync2 & ~(sync2 ^ sync3))
                        | (stable & (sync2 ^ sync3));
            stable_d <= stable;
        end
    end
    assign rise = stable & ~stable_d;
    // ------------------------------------------------------------------
    // power control
    // ------------------------------------------------------------------
    assign loop_on  = (act_loop[LOOP_PWR_HI:LOOP_PWR_LO] == PWR_NORMAL);
    assign diff_sel = act_reference_input_pin[RI_DIFF];
    assign rx_on[0] = loop_on && (diff_sel || act_reference_input_pin[RI_FIRST_EN]);
    assign rx_on[1] = loop_on && !diff_sel && act_reference_input_pin[RI_SECOND_EN];
    // receiver and buffer enables
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_loop_powered     <= 1'b0;
            o_diff_receiver_on <= 1'b0;
            o_first_buffer_on  <= 1'b0;
            o_second_buffer_on <= 1'b0;
        end
        else
        begin
            o_loop_powered     <= loop_on;
            o_diff_receiver_on <= loop_on && diff_sel;
            o_first_buffer_on  <= rx_on[0] && !diff_sel;
            o_second_buffer_on <= rx_on[1];
        end
    end
    // ------------------------------------------------------------------
    // reference validity, one loss timer per input
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 2; g++)
    begin : g_loss
        // an edge restarts the timer and marks the input valid
        always_ff @(posedge i_clock)
        begin
            if (i_rst || !rx_on[g] || rise[g])
            begin
                idle_cnt[g]  <= 8'h00;
                ref_valid[g] <= !i_rst && rx_on[g] && rise[g];
            end
            else if (idle_cnt[g] >= 8'(LOSS_LIMIT))
                ref_valid[g] <= 1'b0;
            else
                idle_cnt[g] <= idle_cnt[g] + 8'h01;
        end
    end
    // ------------------------------------------------------------------
    // reference selection
    // ------------------------------------------------------------------
    always_comb
    begin
        if (diff_sel)
            next_second = 1'b0;
        else if (act_reference_input_pin[RI_AUTO] && act_reference_input_pin[RI_PREF_SECOND])
            next_second = ref_valid[1] || !ref_valid[0];
        else if (act_reference_input_pin[RI_AUTO])
            next_second = !ref_valid[0];
        else if (act_reference_input_pin[RI_USE_PIN])
            next_second = stable[4];
        else
            next_second = act_reference_input_pin[RI_MAN_SECOND];
    end
    // indication sources indexed by monitor code, other codes read 0
    assign pick = {~ref_valid[0], ~ref_valid[1], next_second, 5'h00};
    // active reference and indication outputs
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            sel_second             <= 1'b0;
            o_active_second        <= 1'b0;
            o_ref_loss_monitor_out <= 1'b0;
            o_status_out           <= 1'b0;
        end
        else
        begin
            sel_second             <= next_second;
            o_active_second        <= next_second;
            o_ref_loss_monitor_out <=
                pick[act_mon[MON_PIN_HI:MON_PIN_LO]];
            o_status_out           <=
                pick[act_mon[MON_STAT_HI:MON_STAT_LO]];
        end
    end
    // ------------------------------------------------------------------
    // switchover deglitch
    // ------------------------------------------------------------------
    // after a switch, pass only a reference edge close behind feedback
    always_ff @(posedge i_clock)
    begin
        if (i_rst || act_reference_input_pin[RI_DEGLITCH_OFF] || diff_sel)
        begin
            dg_state  <= PRS_DG_IDLE;
            align_cnt <= 8'h00;
        end
        else if (next_second != sel_second)
        begin
            dg_state  <= PRS_DG_WAIT_FB;
            align_cnt <= 8'h00;
        end
        else
        begin
            case (dg_state)
                PRS_DG_IDLE:
                    align_cnt <= 8'h00;
                PRS_DG_WAIT_FB:
                    if (rise[3])
                    begin
                        dg_state  <= PRS_DG_WAIT_REF;
                        align_cnt <= 8'h00;
                    end
                PRS_DG_WAIT_REF:
                    if (rise[2])
                        dg_state <= PRS_DG_IDLE;
                    else if (align_cnt >= 8'(ALIGN_LIMIT))
                        dg_state <= PRS_DG_WAIT_FB;
                    else
                        align_cnt <= align_cnt + 8'h01;
                default:
                    dg_state <= PRS_DG_IDLE;
            endcase
        end
    end
    assign ref_pass = rise[2] && ((dg_state == PRS_DG_IDLE)
                      || (dg_state == PRS_DG_WAIT_REF));
    // ------------------------------------------------------------------
    // phase detector
    // ------------------------------------------------------------------
    assign pump_mode = act_loop[LOOP_MODE_HI:LOOP_MODE_LO];
    assign pulse_len = act_pulse[PULSE_HI:PULSE_LO] + PULSE_BASE;
    // ref edge sets up, feedback edge sets down, both clear together
    always_ff @(posedge i_clock)
    begin
        if (i_rst || !loop_on || pump_mode != PM_NORMAL
            || (det_up && det_down && clr_cnt + 3'h1 >= pulse_len))
        begin
            det_up   <= 1'b0;
            det_down <= 1'b0;
            clr_cnt  <= 3'h0;
        end
        else if (det_up && det_down)
            clr_cnt <= clr_cnt + 3'h1;
        else
        begin
            if (ref_pass)
                det_up <= 1'b1;
            if (rise[3])
                det_down <= 1'b1;
        end
    end
    // ------------------------------------------------------------------
    // charge pump drive
    // ------------------------------------------------------------------
    always_comb
    begin
        drive_up   = 1'b0;
        drive_down = 1'b0;
        case (pump_mode)
            PM_UP:     drive_up = 1'b1;
            PM_DOWN:   drive_down = 1'b1;
            PM_NORMAL:
            begin
                drive_up   = act_loop[LOOP_POL] ? det_down : det_up;
                drive_down = act_loop[LOOP_POL] ? det_up : det_down;
            end
            default:   ;
        endcase
    end
    // pump outputs, held in high impedance while the loop is down
    always_ff @(posedge i_clock)
    begin
        if (i_rst)
        begin
            o_pump_up            <= 1'b0;
            o_pump_down          <= 1'b0;
            o_pump_hiz           <= 1'b1;
            o_pump_current_units <= 4'h0;
        end
        else
        begin
            o_pump_up            <= loop_on && drive_up;
            o_pump_down          <= loop_on && drive_down;
            o_pump_hiz           <= !loop_on
                                    || !(drive_up || drive_down);
            o_pump_current_units <= {1'b0, act_step[STEP_HI:STEP_LO]}
                                    + STEP_BASE;
        end
    end
endmodule // prs_ctrl

`default_nettype wire

/* File: verif/prs_ctrl_chk.sv */
`timescale 1ns/10ps
`default_nettype none

module prs_ctrl_chk
    import prs_pkg::*;
#(
    parameter int LOSS_LIMIT  = LOSS_CYCLES,
    parameter int ALIGN_LIMIT = ALIGN_CYCLES
)
(
    input wire logic              i_clock,
    input wire logic              i_rst,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_write,
    input wire logic              i_read,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              i_first_reference,
    input wire logic              i_second_reference,
    input wire logic              i_ref_divided,
    input wire logic              i_feedback_divided,
    input wire logic              i_reference_input_pin_select,
    input wire logic              o_pump_up,
    input wire logic              o_pump_down,
    input wire logic              o_pump_hiz,
    input wire logic [3:0]        o_pump_current_units,
    input wire logic              o_loop_powered,
    input wire logic              o_diff_receiver_on,
    input wire logic              o_first_buffer_on,
    input wire logic              o_second_buffer_on,
    input wire logic              o_active_second,
    input wire logic              o_ref_loss_monitor_out,
    input wire logic              o_status_out
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // ------------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------------
    logic commit;
    assign commit = i_write && i_addr == OFF_UPDATE && i_wdata == UPDATE_VALUE;
    sequence s_read_update;
        i_read && i_addr == OFF_UPDATE;
    endsequence
    sequence s_diff_held;
        o_diff_receiver_on [*3];
    endsequence

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_hiz_idle;
        o_pump_hiz |-> !o_pump_up && !o_pump_down;
    endproperty
    property p_diff_excl;
        o_diff_receiver_on |-> !o_first_buffer_on && !o_second_buffer_on;
    endproperty
    property p_loop_off;
        !o_loop_powered && $stable(o_loop_powered) |-> o_pump_hiz &&
            !o_diff_receiver_on && !o_first_buffer_on && !o_second_buffer_on;
    endproperty
    property p_staged_power;
        !$past(i_rst) && $changed(o_loop_powered) |-> $past(commit, 2);
    endproperty
    property p_staged_units;
        !$past(i_rst) && !$past(i_rst, 2) && $changed(o_pump_current_units)
            |-> $past(commit, 2);
    endproperty
    property p_units_range;
        !$past(i_rst) |-> o_pump_current_units inside {[4'h1:4'h8]};
    endproperty
    property p_update_reads_zero;
        s_read_update |=> o_rdata == 8'h00;
    endproperty
    property p_diff_first;
        s_diff_held |-> !o_active_second;
    endproperty

    a_hiz_idle: assert property (p_hiz_idle)
        else $error("pump driven while high impedance");
    a_diff_excl: assert property (p_diff_excl)
        else $error("buffer on in differential mode");
    a_loop_off: assert property (p_loop_off)
        else $error("input or pump active with loop down");
    a_staged_power: assert property (p_staged_power)
        else $error("loop power moved without commit");
    a_staged_units: assert property (p_staged_units)
        else $error("pump current moved without commit");
    a_units_range: assert property (p_units_range)
        else $error("pump current outside eight steps");
    a_update_reads_zero: assert property (p_update_reads_zero)
        else $error("update register read nonzero");
    a_diff_first: assert property (p_diff_first)
        else $error("second reference chosen in differential mode");
endmodule // prs_ctrl_chk

`default_nettype wire

/* File: verif/prs_ref_model.sv */
`timescale 1ns/10ps
`default_nettype none

module prs_ref_model
(
    input  wire logic i_first_run,
    output logic      o_first_reference,
    output logic      o_second_reference,
    output logic      o_ref_divided,
    output logic      o_feedback_divided
);
    // free sources, unrelated to the logic clock; first stops at 0 on demand
    initial
    begin
        o_first_reference  = 1'b0;
        o_second_reference = 1'b0;
        forever
        begin
            #15;
            o_first_reference  = i_first_run & ~o_first_reference;
            #2;
            o_second_reference = ~o_second_reference;
        end
    end
    // divider outputs: reference side leads feedback by 20 ns
    initial
    begin
        o_ref_divided      = 1'b0;
        o_feedback_divided = 1'b0;
        forever
        begin
            #20 o_feedback_divided = o_ref_divided;
            #4 o_ref_divided = ~o_ref_divided;
        end
    end
endmodule // prs_ref_model

`default_nettype wire

/* File: verif/prs_ctrl_test.sv */
`timescale 1ns/10ps
`default_nettype none

module prs_ctrl_test
    import prs_pkg::*;
;
    localparam int LOSS_T = 20;
    logic              i_clock = 1'b0;
    logic              i_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_wdata = '0;
    logic              i_write = 1'b0;
    logic              i_read = 1'b0;
    logic              pin_sel = 1'b0;
    logic              first_run = 1'b1;
    logic [DATA_W-1:0] rdata;
    logic              first_reference, second_reference, rdiv, fdiv, up, dn, hiz, lp;
    logic              dif, b1, b2, act2, mon, stat;
    logic [3:0]        units;
    int                n_errors = 0;
    int                n_compared = 0;
    int                cyc = 0;
    int                nu, nd, lag;

    initial forever #4 i_clock = ~i_clock;

    prs_ctrl #(.LOSS_LIMIT(LOSS_T), .ALIGN_LIMIT(5)) DUT (
        .i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
        .o_rdata(rdata), .i_first_reference(first_reference),
        .i_second_reference(second_reference), .i_ref_divided(rdiv),
        .i_feedback_divided(fdiv), .i_reference_input_pin_select(pin_sel),
        .o_pump_up(up), .o_pump_down(dn), .o_pump_hiz(hiz),
        .o_pump_current_units(units), .o_loop_powered(lp),
        .o_diff_receiver_on(dif), .o_first_buffer_on(b1),
        .o_second_buffer_on(b2), .o_active_second(act2),
        .o_ref_loss_monitor_out(mon), .o_status_out(stat));
    prs_ref_model u_src (.i_first_run(first_run), .o_first_reference(first_reference),
        .o_second_reference(second_reference), .o_ref_divided(rdiv),
        .o_feedback_divided(fdiv));

    // ------------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_addr  <= a;
        i_wdata <= d;
        i_write <= 1'b1;
        @(posedge i_clock);
        i_write <= 1'b0;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h0, got}, {7'h0, exp});
    endtask
    task automatic chk_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge i_clock);
        i_addr <= a;
        i_read <= 1'b1;
        @(posedge i_clock);
        i_read <= 1'b0;
        #1;
        chk_byte(rdata, e);
    endtask
    task automatic commit;
        wr(OFF_UPDATE, UPDATE_VALUE);
        repeat (3) @(posedge i_clock);
        #1;
    endtask
    // cycles with each pump command high over sixteen compare periods
    task automatic measure;
        nu = 0;
        nd = 0;
        repeat (96)
        begin
            @(posedge i_clock);
            #1;
            nu += int'(up === 1'b1);
            nd += int'(dn === 1'b1);
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard
    always @(posedge i_clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge i_clock);
        i_rst <= 1'b0;
        chk_reg(OFF_LOOP_MAIN, RST_LOOP_MAIN);
        chk_reg(OFF_REF_INPUT, RST_ZERO);
        chk_bit(b1 | b2 | dif | lp, 1'b0);
        wr(OFF_LOOP_MAIN, 8'h30);
        chk_reg(OFF_LOOP_MAIN, 8'h30);
        wr(OFF_UPDATE, 8'h02);
        repeat (3) @(posedge i_clock);
        chk_bit(lp, 1'b0);
        commit();
        chk_bit(lp, 1'b1);
        chk_reg(OFF_UPDATE, 8'h00);
        chk_reg(10'h3ff, 8'h00);
        for (int s = 0; s < 8; s++)
        begin
            wr(OFF_PUMP_STEP, 8'(s));
            commit();
            chk_byte({4'h0, units}, 8'(s + 1));
        end
        for (int m = 0; m < 3; m++)
        begin
            wr(OFF_LOOP_MAIN, {1'b0, 3'(m), 4'h0});
            commit();
            chk_byte({5'h0, up, dn, hiz}, 8'(m == 1 ? 4 : m == 2 ? 2 : 1));
        end
        wr(OFF_REF_INPUT, 8'h06);
        for (int p = 0; p < 2; p++)
        begin
            wr(OFF_LOOP_MAIN, {p[0], 7'h30});
            commit();
            measure();
            chk_bit(nu > nd, p == 0);
        end
        lag = nu;
        wr(OFF_DET_PULSE, 8'h03);
        commit();
        measure();
        chk_bit(nu > lag, 1'b1);
        wr(OFF_REF_INPUT, 8'h17);
        commit();
        chk_byte({5'h0, dif, b1 | b2, act2}, 8'h04);
        wr(OFF_REF_INPUT, 8'h04);
        commit();
        chk_byte({5'h0, dif, b1, b2}, 8'h01);
        wr(OFF_LOOP_MAIN, 8'h31);
        commit();
        chk_bit(b2 | ~hiz, 1'b0);
        wr(OFF_LOOP_MAIN, 8'h30);
        wr(OFF_REF_INPUT, 8'h16);
        commit();
        repeat (20) @(posedge i_clock);
        chk_bit(act2, 1'b1);
        wr(OFF_REF_INPUT, 8'h46);
        commit();
        repeat (20) @(posedge i_clock);
        chk_bit(act2, 1'b0);
        pin_sel <= 1'b1;
        repeat (20) @(posedge i_clock);
        chk_bit(act2, 1'b1);
        wr(OFF_MON_CONFIG, 8'hf7);
        wr(OFF_REF_INPUT, 8'h26);
        commit();
        repeat (20) @(posedge i_clock);
        chk_byte({6'h0, mon, act2}, 8'h00);
        first_run <= 1'b0;
        repeat (LOSS_T + 20) @(posedge i_clock);
        chk_byte({6'h0, mon, act2}, 8'h03);
        first_run <= 1'b1;
        repeat (20) @(posedge i_clock);
        chk_byte({6'h0, mon, act2}, 8'h00);
        wr(OFF_MON_CONFIG, 8'h70);
        wr(OFF_REF_INPUT, 8'h2e);
        commit();
        repeat (20) @(posedge i_clock);
        chk_byte({6'h0, stat, act2}, 8'h01);
        first_run <= 1'b0;
        repeat (LOSS_T + 20) @(posedge i_clock);
        chk_byte({6'h0, stat, act2}, 8'h03);
        tally_and_finish();
    end
endmodule // prs_ctrl_test

bind prs_ctrl prs_ctrl_chk #(.LOSS_LIMIT(LOSS_LIMIT), .ALIGN_LIMIT(ALIGN_LIMIT))
    u_chk (.*);

`default_nettype wire
